// ===== hw/sswl_status.sv
// Status word generator for the networked stepper indexer
`timescale 1ns/100ps

// Notes on behaviour
// - Word0 bit15 high in configuration mode
// - Start command mode; no power without configuration
// - Word0 bit14 high unless internal fault
// - Config error until valid config; set on invalid
// - Config error also when stall detect in config
// - Command error sticky until reset-errors
// - Input error on estop and limits; reset clears
// - Position invalid on listed events
// - Absolute moves refused while position invalid
// - Bit8 assembled ready, bit9 segment wanted
// - Move done on success; cleared by move/preset/reset
// - Move done also with bad jog parameters
// - Bit6 decelerating, bit5 accelerating only
// - Bit3 whenever motor not moving
// - Bit1 CCW, bit0 CW, bit2 hold
// - Word1 bit15 shows global driver enable
// - Heartbeat toggles 500 ms in command mode
// - Limit condition set on limit, cleared release
// - Jog change or bad gearing sets bit9
// - Driver fault shown while driver enabled
// - Clear-fault block clears fault, motor unpowered
// - Link re-established sets bit6 and input error
module sswl_status
    import sswl_pkg::*;
#(
    parameter int HEARTBEAT_CYCLES = HEARTBEAT_CYC  // Half period of beat
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    // Host command words, with a one-cycle write strobe
    input  wire logic          cmd_wr_i,
    input  wire logic [15:0]   cmd_word0_i,
    input  wire logic [15:0]   cmd_word1_i,
    // Mode and configuration
    input  wire logic          cfg_mode_i,
    input  wire logic          stall_detect_en_i,
    input  wire logic          gear_mode_i,
    input  wire logic [7:0]    gear_num_i,
    input  wire logic [7:0]    gear_den_i,
    // Internal state and events
    input  wire logic          internal_fault_i,
    input  wire sswl_motion_s  motion_i,
    input  wire sswl_event_s   event_i,
    input  wire logic          dc_output_i,
    // Asynchronous pins from the power stage and inputs
    input  wire logic          overtemp_pin_i,
    input  wire logic          short_pin_i,
    input  wire logic          temp_high_pin_i,
    input  wire logic [2:0]    inputs_active_pin_i,
    // Status words and control outputs
    output logic [15:0]        motion_status_word_o,
    output logic [15:0]        drive_status_word_o,
    output logic               motor_power_o,
    output logic               accept_cmds_o,
    output logic               abs_move_go_o
);

    // Two-stage synchronisers for the pins
    logic [5:0] sync_a;               // First stage, read only by second
    logic [5:0] sync_b;               // Second stage, safe to use
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= {overtemp_pin_i, short_pin_i, temp_high_pin_i,
                       inputs_active_pin_i};
            sync_b <= sync_a;
        end
    end

    // Synchronised pin views
    wire       overtemp   = sync_b[5];
    wire       shorted    = sync_b[4];
    wire       temp_high  = sync_b[3];
    wire [2:0] ins_active = sync_b[2:0];

    // Sticky and state flags
    logic cfg_valid;                  // Holds a valid configuration
    logic cfg_err;                    // Configuration error flag
    logic cmd_err;                    // Command error flag
    logic input_err;                  // Input error flag
    logic pos_invalid;                // Position invalid flag
    logic move_done;                  // Move complete flag
    logic in_asm;                     // Assembled programming mode
    logic wait_seg;                   // Waiting for segment
    logic limit_cond;                 // Limit condition flag
    logic jog_change;                 // Invalid jog change flag
    logic drv_fault;                  // Latched driver fault
    logic link_lost;                  // Connection was lost flag
    logic drv_enable;                 // Global driver enable
    logic heartbeat;                  // Heartbeat level
    logic [31:0] beat_cnt;            // Heartbeat counter

    // Command decode
    wire reset_errors = cmd_wr_i & cmd_word1_i[CW1_RESET_ERRORS];
    wire fault_clear  = cmd_wr_i & (cmd_word0_i == FAULT_CLEAR_WORD)
                        & (cmd_word1_i == FAULT_CLEAR_WORD);
    wire gear_bad     = gear_mode_i & ((gear_num_i == 8'h00)
                        | (gear_den_i == 8'h00));
    wire cmd_ok       = cfg_valid & ~cfg_mode_i;
    wire hw_fault     = overtemp | shorted;

    // Event terms for the sticky flags
    wire set_input = event_i.estop | event_i.limit_in_move
                     | event_i.jog_into_limit | event_i.home_far_limit
                     | event_i.link_restored;
    wire set_pos   = event_i.cfg_valid_wr | event_i.cfg_invalid_wr
                     | event_i.link_restored | event_i.net_restored
                     | event_i.istop | event_i.estop
                     | event_i.limit_in_move | event_i.home_far_limit
                     | event_i.jog_into_limit | motion_i.stall;
    wire clr_pos   = event_i.preset | event_i.home_ok;
    wire set_done  = event_i.move_ok | event_i.bad_jog_params;
    wire clr_done  = event_i.move_cmd | event_i.preset | reset_errors;
    wire set_limit = event_i.limit_in_move | event_i.home_far_limit;

    // Configuration validity and error
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_valid <= 1'b0;
            cfg_err   <= 1'b1;
        end else if (event_i.cfg_invalid_wr) begin
            cfg_valid <= 1'b0;
            cfg_err   <= 1'b1;
        end else if (event_i.cfg_valid_wr | event_i.cfg_restored) begin
            cfg_valid <= 1'b1;
            cfg_err   <= 1'b0;
        end
    end

    // Sticky error flags; a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmd_err    <= 1'b0;
            input_err  <= 1'b0;
            limit_cond <= 1'b0;
            jog_change <= 1'b0;
            link_lost  <= 1'b0;
        end else begin
            cmd_err    <= event_i.bad_cmd | event_i.bad_jog_params
                          | (cmd_err & ~reset_errors);
            input_err  <= set_input | (input_err & ~reset_errors);
            limit_cond <= set_limit | (limit_cond & ~reset_errors
                          & ~event_i.limit_release);
            jog_change <= event_i.jog_bad_change | gear_bad
                          | (jog_change & ~reset_errors);
            link_lost  <= event_i.link_restored
                          | (link_lost & ~reset_errors);
        end
    end

    // Position validity and move completion
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pos_invalid <= 1'b1;
            move_done   <= 1'b0;
        end else begin
            pos_invalid <= set_pos | (pos_invalid & ~clr_pos);
            move_done   <= set_done | (move_done & ~clr_done);
        end
    end

    // Assembled move handshake; a set in the clearing cycle wins, except asm_end beats seg_released
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            in_asm   <= 1'b0;
            wait_seg <= 1'b0;
        end else if (event_i.asm_ready) begin
            in_asm   <= 1'b1;
            wait_seg <= 1'b1;
        end else if (event_i.asm_end) begin
            in_asm   <= 1'b0;         // Programming over
            wait_seg <= 1'b0;
        end else if (event_i.seg_released & in_asm) begin
            wait_seg <= 1'b1;
        end else if (event_i.seg_taken) begin
            wait_seg <= 1'b0;
        end
    end

    // Driver enable and driver fault latch
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            drv_enable <= 1'b0;
            drv_fault  <= 1'b0;
        end else begin
            if (cmd_wr_i) begin
                drv_enable <= cmd_word1_i[CW1_DRV_ENABLE];
            end
            if (drv_enable & hw_fault) begin
                drv_fault <= 1'b1;
            end else if (fault_clear) begin
                drv_fault <= 1'b0;
            end
        end
    end

    // Heartbeat, running only in command mode
    always_ff @(posedge clk_i) begin
        if (reset_i | cfg_mode_i) begin
            beat_cnt  <= 32'h0;
            heartbeat <= 1'b0;
        end else if (beat_cnt == 32'(HEARTBEAT_CYCLES - 1)) begin
            beat_cnt  <= 32'h0;
            heartbeat <= ~heartbeat;
        end else begin
            beat_cnt  <= beat_cnt + 32'h1;
        end
    end

    // Status word 0 assembly
    logic [15:0] next_w0;
    always_comb begin
        next_w0                  = 16'h0000;
        next_w0[W0_MODE_CFG]     = cfg_mode_i;
        next_w0[W0_MODULE_OK]    = ~internal_fault_i;
        next_w0[W0_CFG_ERR]      = cfg_err
                                   | (stall_detect_en_i & cfg_mode_i);
        next_w0[W0_CMD_ERR]      = cmd_err;
        next_w0[W0_INPUT_ERR]    = input_err;
        next_w0[W0_POS_INVALID]  = pos_invalid;
        next_w0[W0_WAIT_SEGMENT] = wait_seg;
        next_w0[W0_IN_ASSEMBLED] = in_asm;
        next_w0[W0_MOVE_DONE]    = move_done;
        next_w0[W0_DECEL]        = motion_i.phase == SSWL_DECEL;
        next_w0[W0_ACCEL]        = motion_i.phase == SSWL_ACCEL;
        next_w0[W0_HOMING_DONE]  = motion_i.homed;
        next_w0[W0_STOPPED]      = motion_i.phase == SSWL_IDLE;
        next_w0[W0_IN_HOLD]      = motion_i.in_hold;
        next_w0[W0_CCW]          = (motion_i.phase != SSWL_IDLE)
                                   & motion_i.dir_ccw;
        next_w0[W0_CW]           = (motion_i.phase != SSWL_IDLE)
                                   & ~motion_i.dir_ccw;
    end

    // Status word 1 assembly
    logic [15:0] next_w1;
    always_comb begin
        next_w1                  = 16'h0000;
        next_w1[W1_POWER_STAGE]  = drv_enable;
        next_w1[W1_STALL]        = motion_i.stall;
        next_w1[W1_OUTPUT_STATE] = dc_output_i;
        next_w1[W1_HEARTBEAT]    = heartbeat;
        next_w1[W1_LIMIT_COND]   = limit_cond;
        next_w1[W1_JOG_CHANGE]   = jog_change;
        next_w1[W1_MOTION_LAG]   = motion_i.lag;
        next_w1[W1_DRIVER_FAULT] = drv_fault;
        next_w1[W1_LINK_LOST]    = link_lost;
        next_w1[W1_HOT]          = temp_high;
        next_w1[2:0]             = ins_active;
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            motion_status_word_o <= W0_RESET;
            drive_status_word_o  <= W1_RESET;
            motor_power_o        <= 1'b0;
            accept_cmds_o        <= 1'b0;
            abs_move_go_o        <= 1'b0;
        end else begin
            motion_status_word_o <= next_w0;
            drive_status_word_o  <= next_w1;
            // No current while a fault stands, even before it latches
            motor_power_o        <= drv_enable & ~drv_fault & ~hw_fault
                                    & cfg_valid;
            accept_cmds_o        <= cmd_ok;
            abs_move_go_o        <= event_i.abs_move_cmd & cmd_ok
                                    & ~pos_invalid;
        end
    end

    // Checks on the outputs and internal flags
    a_mode_bit_follow: assert property (@(posedge clk_i) disable iff
        (reset_i) ##1 motion_status_word_o[W0_MODE_CFG]
        == $past(cfg_mode_i)) else $error("mode bit wrong");
    a_no_power_unconf: assert property (@(posedge clk_i) disable iff
        (reset_i) !cfg_valid |=> !motor_power_o)
        else $error("power without config");
    a_ok_bit_fault: assert property (@(posedge clk_i) disable iff
        (reset_i) internal_fault_i |=> !motion_status_word_o[W0_MODULE_OK])
        else $error("ok bit during fault");
    a_cfg_err_set: assert property (@(posedge clk_i) disable iff
        (reset_i) event_i.cfg_invalid_wr |-> ##2
        motion_status_word_o[W0_CFG_ERR]) else $error("cfg err");
    a_cmd_err_hold: assert property (@(posedge clk_i) disable iff
        (reset_i) cmd_err && !reset_errors |=> cmd_err)
        else $error("cmd err lost");
    a_abs_refused: assert property (@(posedge clk_i) disable iff
        (reset_i) pos_invalid |=> !abs_move_go_o)
        else $error("absolute move while invalid");
    a_phase_bits_excl: assert property (@(posedge clk_i) disable iff
        (reset_i) !(motion_status_word_o[W0_DECEL]
        && motion_status_word_o[W0_ACCEL])) else $error("phase");
    a_fault_clear: assert property (@(posedge clk_i) disable iff
        (reset_i) fault_clear && !(drv_enable && hw_fault) |-> ##2
        !drive_status_word_o[W1_DRIVER_FAULT] && !motor_power_o)
        else $error("fault not cleared");
    a_link_sets_two: assert property (@(posedge clk_i) disable iff
        (reset_i) event_i.link_restored |=> link_lost && input_err)
        else $error("link restore flags");
    a_seg_set_wins: assert property (@(posedge clk_i) disable iff
        (reset_i) event_i.seg_released && in_asm && !event_i.asm_end
        |=> wait_seg) else $error("segment request lost");
    a_beat_held_cfg: assert property (@(posedge clk_i) disable iff
        (reset_i) cfg_mode_i |=> !heartbeat)
        else $error("heartbeat in config mode");

endmodule

// ===== inc/sswl_pkg.sv
// Package for the stepper status word logic: bit positions, codes, timing
package sswl_pkg;

    // Status word 0 bit positions
    localparam int W0_MODE_CFG      = 15;
    localparam int W0_MODULE_OK     = 14;
    localparam int W0_CFG_ERR       = 13;
    localparam int W0_CMD_ERR       = 12;
    localparam int W0_INPUT_ERR     = 11;
    localparam int W0_POS_INVALID   = 10;
    localparam int W0_WAIT_SEGMENT  = 9;
    localparam int W0_IN_ASSEMBLED  = 8;
    localparam int W0_MOVE_DONE     = 7;
    localparam int W0_DECEL         = 6;
    localparam int W0_ACCEL         = 5;
    localparam int W0_HOMING_DONE   = 4;
    localparam int W0_STOPPED       = 3;
    localparam int W0_IN_HOLD       = 2;
    localparam int W0_CCW           = 1;
    localparam int W0_CW            = 0;

    // Status word 1 bit positions
    localparam int W1_POWER_STAGE   = 15;
    localparam int W1_STALL         = 14;
    localparam int W1_OUTPUT_STATE  = 13;
    localparam int W1_HEARTBEAT     = 11;
    localparam int W1_LIMIT_COND    = 10;
    localparam int W1_JOG_CHANGE    = 9;
    localparam int W1_MOTION_LAG    = 8;
    localparam int W1_DRIVER_FAULT  = 7;
    localparam int W1_LINK_LOST     = 6;
    localparam int W1_HOT           = 4;

    // Command word bit positions
    localparam int CW1_RESET_ERRORS = 10;
    localparam int CW1_DRV_ENABLE   = 15;

    // Driver fault clear block value for both command words
    localparam logic [15:0] FAULT_CLEAR_WORD = 16'h0400;

    // Status word value after reset: command mode, config error shown
    localparam logic [15:0] W0_RESET = 16'h2008;
    localparam logic [15:0] W1_RESET = 16'h0000;

    // Heartbeat timing
    localparam int  CLK_HZ          = 40_000_000;
    localparam int  HEARTBEAT_MS    = 500;
    localparam int  HEARTBEAT_CYC   = CLK_HZ / 1000 * HEARTBEAT_MS;

    // Motion phase of the profile generator
    typedef enum logic [1:0] {
        SSWL_IDLE,
        SSWL_ACCEL,
        SSWL_CRUISE,
        SSWL_DECEL
    } sswl_phase_e;

    // Motion state from the profile generator
    typedef struct packed {
        sswl_phase_e phase;      // Present profile phase
        logic        dir_ccw;    // Direction while moving
        logic        in_hold;    // Move held
        logic        homed;      // Homing finished
        logic        stall;      // Stall seen
        logic        lag;        // Motion lag
    } sswl_motion_s;

    // One-cycle events from the motion and command logic
    typedef struct packed {
        logic cfg_valid_wr;      // Valid configuration written
        logic cfg_invalid_wr;    // Invalid configuration written
        logic cfg_restored;      // Valid configuration from storage
        logic bad_cmd;           // Invalid command
        logic bad_jog_params;    // Jog or registration out of range
        logic move_cmd;          // New move command
        logic abs_move_cmd;      // Absolute move requested
        logic move_ok;           // Move finished without error
        logic preset;            // Position preset
        logic home_ok;           // Homing finished
        logic estop;             // Emergency stop input
        logic istop;             // Immediate stop
        logic limit_in_move;     // End limit during non-homing move
        logic jog_into_limit;    // Jog toward active limit
        logic home_far_limit;    // Opposite limit while homing
        logic limit_release;     // Limit input went inactive
        logic jog_bad_change;    // Invalid mid-jog change
        logic link_restored;     // Physical link re-established
        logic net_restored;      // Non-physical connection back
        logic asm_ready;         // Assembled programming accepted
        logic seg_taken;         // Segment block taken
        logic seg_released;      // Host released segment bit
        logic asm_end;           // Assembled programming ended
    } sswl_event_s;

endpackage

// ===== verif/sswl_host_model.sv
// Host controller model that writes command word blocks
`timescale 1ns/100ps
module sswl_host_model
    import sswl_pkg::*;
(
    // Clock
    input  wire logic   clk_i,
    // Command block towards the device
    output logic        cmd_wr_o,
    output logic [15:0] cmd_word0_o,
    output logic [15:0] cmd_word1_o
);
    // Nothing written yet
    initial begin
        cmd_wr_o    = 1'b0;
        cmd_word0_o = 16'h0000;
        cmd_word1_o = 16'h0000;
    end
    // One block for one edge; stale words scrambled afterwards
    task automatic write_block(input logic [15:0] w0,
                               input logic [15:0] w1);
        cmd_wr_o    = 1'b1;
        cmd_word0_o = w0;
        cmd_word1_o = w1;
        @(posedge clk_i);
        #2;
        cmd_wr_o    = 1'b0;
        cmd_word0_o = ~w0;
        cmd_word1_o = ~w1;
    endtask
    // Reset errors, driver left off
    task automatic reset_errors();
        write_block(16'h0000, 16'h0400);
    endtask
    // Fault clear block, same value in both words
    task automatic clear_fault();
        write_block(FAULT_CLEAR_WORD, FAULT_CLEAR_WORD);
    endtask
    // Driver enable only
    task automatic enable();
        write_block(16'h0000, 16'h8000);
    endtask
endmodule

// ===== verif/sswl_status_test.sv
// Self-checking bench for the status word generator
`timescale 1ns/100ps
module sswl_status_test
    import sswl_pkg::*;
;
    logic         clk_i = 1'b0;   // Bench clock
    logic         reset_i = 1'b1; // Sync reset
    logic         cmd_wr;         // Host strobe
    logic [15:0]  cw0;            // Host word 0
    logic [15:0]  cw1;            // Host word 1
    logic         cfg_mode;       // Configuration mode
    logic         stall_en;       // Stall detection on
    logic         gear_mode;      // Gearing mode
    logic [7:0]   gear_num;       // Gear numerator
    logic [7:0]   gear_den;       // Gear denominator
    logic         int_fault;      // Internal fault
    logic         overtemp;       // Overtemperature pin
    logic         shorted;        // Short circuit pin
    sswl_motion_s mot;            // Motion state
    sswl_event_s  ev;             // Events driven
    sswl_event_s  ev_q;           // Next event to fire
    logic [15:0]  w0;             // Status word 0
    logic [15:0]  w1;             // Status word 1
    logic         mpow;           // Motor power
    logic         acc;            // Commands accepted
    logic         go;             // Absolute move passed
    int           n_errors = 0;   // Mismatches
    int           checked = 0;    // Comparisons
    int           n_go = 0;       // Absolute moves passed

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    // Count passed absolute moves
    always @(posedge clk_i) begin
        if (go === 1'b1) begin
            n_go++;
        end
    end

    sswl_status #(.HEARTBEAT_CYCLES(4)) i_dut (
        .clk_i(clk_i), .reset_i(reset_i), .cmd_wr_i(cmd_wr),
        .cmd_word0_i(cw0), .cmd_word1_i(cw1), .cfg_mode_i(cfg_mode),
        .stall_detect_en_i(stall_en), .gear_mode_i(gear_mode),
        .gear_num_i(gear_num), .gear_den_i(gear_den),
        .internal_fault_i(int_fault), .motion_i(mot), .event_i(ev),
        .dc_output_i(1'b0), .overtemp_pin_i(overtemp),
        .short_pin_i(shorted), .temp_high_pin_i(1'b0),
        .inputs_active_pin_i(3'h0), .motion_status_word_o(w0),
        .drive_status_word_o(w1), .motor_power_o(mpow),
        .accept_cmds_o(acc), .abs_move_go_o(go));
    sswl_host_model i_host (.clk_i(clk_i), .cmd_wr_o(cmd_wr),
        .cmd_word0_o(cw0), .cmd_word1_o(cw1));

    // Compare and report
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Wait edges, then step off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    // Pulse queued events one cycle, wait for the words
    task automatic fire();
        ev = ev_q;
        ev_q = '0;
        wt(1);
        ev = '0;
        wt(2);
    endtask
    // Reset errors and let it land
    task automatic errs();
        i_host.reset_errors();
        wt(2);
    endtask
    // Reset values and first computed word
    task automatic t_reset();
        wt(8);
        chk("w0 in reset", W0_RESET, w0);
        wt(8);
        reset_i = 1'b0;
        wt(1);
        chk("w0 after reset", 16'h6408, w0);
        chk("w1 after reset", 16'h0000, w1 & 16'hf7ff);
        chk("power at start", 16'h0000, {15'h0, mpow});
        chk("accept at start", 16'h0000, {15'h0, acc});
    endtask
    // Modes, configuration and heartbeat
    task automatic t_config();
        int h;
        h = 0;
        ev_q.cfg_valid_wr = 1'b1;
        fire();
        chk("cfg ok", 16'h0000, w0 & 16'h2000);
        chk("accept", 16'h0001, {15'h0, acc});
        cfg_mode = 1'b1;
        wt(3);
        chk("cfg mode", 16'h8000, w0 & 16'ha000);
        chk("no accept", 16'h0000, {15'h0, acc});
        stall_en = 1'b1;
        wt(3);
        chk("stall cfg", 16'h2000, w0 & 16'h2000);
        repeat (12) begin
            wt(1);
            chk("beat cfg", 16'h0000, w1 & 16'h0800);
        end
        cfg_mode = 1'b0;
        stall_en = 1'b0;
        repeat (12) begin
            wt(1);
            h += int'(w1[W1_HEARTBEAT] === 1'b1);
        end
        chk("beat runs", 16'h0001, {15'h0, h > 2 && h < 10});
        ev_q.cfg_invalid_wr = 1'b1;
        fire();
        chk("cfg bad", 16'h2000, w0 & 16'h2000);
        ev_q.cfg_restored = 1'b1;
        fire();
        chk("cfg restored", 16'h0000, w0 & 16'h2000);
        int_fault = 1'b1;
        wt(3);
        chk("module fault", 16'h0000, w0 & 16'h4000);
        int_fault = 1'b0;
    endtask
    // Position validity and absolute moves
    task automatic t_position();
        ev_q.abs_move_cmd = 1'b1;
        fire();
        chk("abs refused", 16'h0000, 16'(n_go));
        ev_q.preset = 1'b1;
        fire();
        chk("pos valid", 16'h0000, w0 & 16'h0400);
        ev_q.abs_move_cmd = 1'b1;
        fire();
        chk("abs passed", 16'h0001, 16'(n_go));
        ev_q.cfg_valid_wr = 1'b1;
        fire();
        chk("pos cfg", 16'h0400, w0 & 16'h0400);
        ev_q.preset = 1'b1;
        fire();
        ev_q.estop = 1'b1;
        fire();
        chk("estop", 16'h0c00, w0 & 16'h0c00);
        errs();
    endtask
    // Command error and move done
    task automatic t_cmd_err();
        ev_q.bad_cmd = 1'b1;
        fire();
        chk("bad cmd", 16'h1000, w0 & 16'h1080);
        errs();
        chk("cmd err clr", 16'h0000, w0 & 16'h1000);
        ev_q.bad_jog_params = 1'b1;
        fire();
        chk("bad jog", 16'h1080, w0 & 16'h1080);
        ev_q.move_cmd = 1'b1;
        fire();
        chk("done clr", 16'h0000, w0 & 16'h0080);
        ev_q.move_ok = 1'b1;
        fire();
        chk("done", 16'h0080, w0 & 16'h0080);
        errs();
        chk("errs clr", 16'h0000, w0 & 16'h1880);
        ev_q.home_ok = 1'b1;
        fire();
        chk("home no done", 16'h0000, w0 & 16'h0080);
        ev_q.asm_ready = 1'b1;
        fire();
        chk("asm ready", 16'h0300, w0 & 16'h0300);
        ev_q.seg_taken = 1'b1;
        fire();
        chk("seg taken", 16'h0100, w0 & 16'h0300);
        ev_q.seg_released = 1'b1;
        fire();
        chk("seg wanted", 16'h0300, w0 & 16'h0300);
        ev_q.asm_end = 1'b1;
        fire();
        chk("asm end", 16'h0000, w0 & 16'h0100);
    endtask
    // Motion phase and direction bits
    task automatic t_phase();
        mot.phase = SSWL_ACCEL;
        wt(3);
        chk("accel cw", 16'h0021, w0 & 16'h006f);
        mot.phase = SSWL_DECEL;
        mot.dir_ccw = 1'b1;
        wt(3);
        chk("decel ccw", 16'h0042, w0 & 16'h006f);
        mot.phase = SSWL_CRUISE;
        mot.dir_ccw = 1'b0;
        mot.in_hold = 1'b1;
        wt(3);
        chk("hold", 16'h0005, w0 & 16'h006f);
        mot = '0;
        wt(3);
        chk("idle", 16'h0008, w0 & 16'h006f);
    endtask
    // Limits, jog changes, gearing, link loss
    task automatic t_limit();
        ev_q.limit_in_move = 1'b1;
        fire();
        chk("limit", 16'h0400, w1 & 16'h0400);
        chk("limit in err", 16'h0800, w0 & 16'h0800);
        ev_q.limit_release = 1'b1;
        fire();
        chk("limit off", 16'h0000, w1 & 16'h0400);
        ev_q.jog_bad_change = 1'b1;
        fire();
        chk("jog change", 16'h0200, w1 & 16'h0200);
        errs();
        chk("jog clr", 16'h0000, w1 & 16'h0200);
        ev_q.jog_into_limit = 1'b1;
        fire();
        chk("jog limit", 16'h0800, w0 & 16'h0800);
        errs();
        ev_q.home_far_limit = 1'b1;
        fire();
        chk("home limit", 16'h0800, w0 & 16'h0800);
        errs();
        gear_mode = 1'b1;
        gear_num = 8'h00;
        wt(3);
        chk("gear bad", 16'h0200, w1 & 16'h0200);
        gear_mode = 1'b0;
        gear_num = 8'h01;
        errs();
        ev_q.net_restored = 1'b1;
        fire();
        chk("net back", 16'h0000, w1 & 16'h0040);
        ev_q.link_restored = 1'b1;
        fire();
        chk("link back", 16'h0040, w1 & 16'h0040);
        chk("link in err", 16'h0800, w0 & 16'h0800);
        errs();
    endtask
    // Driver enable and fault clear
    task automatic t_fault();
        overtemp = 1'b1;
        wt(6);
        chk("fault off drv", 16'h0000, w1 & 16'h0080);
        i_host.enable();
        wt(6);
        chk("fault", 16'h8080, w1 & 16'h8080);
        chk("fault power", 16'h0000, {15'h0, mpow});
        overtemp = 1'b0;
        wt(6);
        i_host.clear_fault();
        wt(3);
        chk("fault clr", 16'h0000, w1 & 16'h8080);
        chk("clr power", 16'h0000, {15'h0, mpow});
        i_host.enable();
        wt(3);
        chk("re-enable", 16'h0001, {15'h0, mpow});
        shorted = 1'b1;
        wt(6);
        chk("short fault", 16'h0080, w1 & 16'h0080);
        chk("short power", 16'h0000, {15'h0, mpow});
        shorted = 1'b0;
        wt(3);
        i_host.clear_fault();
        wt(3);
        chk("short clr", 16'h0000, w1 & 16'h8080);
    endtask
    // Verdict and end of run
    task automatic give_verdict();
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {cfg_mode, stall_en, gear_mode, int_fault, overtemp} = 5'h00;
        shorted = 1'b0;
        gear_num = 8'h01;
        gear_den = 8'h10;
        mot = '0;
        ev = '0;
        ev_q = '0;
        t_reset();
        t_config();
        t_position();
        t_cmd_err();
        t_phase();
        t_limit();
        t_fault();
        give_verdict();
    end
    // Watchdog far beyond the expected run
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
endmodule
